// ### hw/sscr_supervisor.sv
// supply and stall reset supervisor with apb control register
//
// What this block does
// - 20-bit stall counter on oscillation clock; reset when it expires.
// - stall-expiry internal reset lasts exactly five machine cycles.
// - counter starts by itself once power-on reset is released.
// - clear bit zero, internal reset, clock stop, sleep, timebase clear it.
// - counter held cleared whenever the processor stops executing.
// - counter stops while running from the sub-oscillation clock.
// - no software means disables the counter or supply detection.
// - writing zero to bit3 restarts the stall counter from zero.
// - low supply sets bit2 flag and asserts internal reset.
// - writing zero clears the low-supply flag; one leaves it.
// - overflow sets bit0 flag; zero write clears, one has no effect.
// - cause flags survive internal resets; only external reset clears.
// - supply detection keeps working in stop mode and ends it by reset.
// - both checks resume right after reset, with no stabilisation wait.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module sscr_supervisor #(
    parameter int STALL_WIDTH = sscr_pkg::SSCR_STALL_WIDTH,
    parameter int RESET_CYCLES = sscr_pkg::SSCR_RESET_CYCLES,
    parameter int FILTER_CYCLES = sscr_pkg::SSCR_FILTER_CYCLES
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic OSC_RUN_I,
    input wire logic MACHINE_TICK_I,
    input wire sscr_pkg::sscr_mode_t POWER_MODE_I,
    input wire logic LOW_SUPPLY_I,
    output logic INT_RESET_O,
    output logic STOP_WAKE_O
);
    import sscr_pkg::*;

    // refuse sizes that the counters below cannot hold
    if (STALL_WIDTH < 2 || STALL_WIDTH > 32) begin : g_bad_width
        $error("stall counter width out of range");
    end
    if (RESET_CYCLES < 1 || RESET_CYCLES > 255) begin : g_bad_reset
        $error("reset width out of range");
    end

    // ========================================================
    // apb decode helper, used for reads and writes
    function automatic logic hit_ctrl(input logic [11:0] a);
        hit_ctrl = (a == SSCR_CTRL_STATUS_OFS);
    endfunction : hit_ctrl

    // ========================================================
    // synchronisers for asynchronous pins
    logic low_meta_q, low_sync_q;
    logic osc_meta_q, osc_sync_q;
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            low_meta_q <= 1'b0;
            low_sync_q <= 1'b0;
            osc_meta_q <= 1'b0;
            osc_sync_q <= 1'b0;
        end else begin
            low_meta_q <= LOW_SUPPLY_I;
            low_sync_q <= low_meta_q;
            osc_meta_q <= OSC_RUN_I;
            osc_sync_q <= osc_meta_q;
        end
    end

    // ========================================================
    // noise filter on the comparator
    sscr_flt_if flt_bus();
    assign flt_bus.raw_sync = low_sync_q;

    sscr_noise_filter #(
        .STABLE_CYCLES(FILTER_CYCLES)
    ) u_filter (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .flt(flt_bus.filt)
    );

    logic low_conf;
    logic low_conf_prev_q;
    logic low_rise;
    assign low_conf = flt_bus.confirmed;
    // a rising confirmation is one detection event
    assign low_rise = low_conf & ~low_conf_prev_q;

    // ========================================================
    // apb transfer qualification
    logic apb_acc, apb_wr, ctrl_wr;
    assign apb_acc = PSEL_I & PENABLE_I;
    assign apb_wr = apb_acc & PWRITE_I;
    // writes need the low byte lane; other lanes hold nothing
    assign ctrl_wr = apb_wr & hit_ctrl(PADDR_I) & PSTRB_I[0];

    logic clear_wr;
    assign clear_wr = ctrl_wr & ~PWDATA_I[SSCR_CLEAR_BIT];

    // ========================================================
    // stall counter
    logic [STALL_WIDTH-1:0] stall_q, stall_d;
    logic stall_ovf;
    sscr_rst_state_t rst_st_q, rst_st_d;
    logic [7:0] rst_cnt_q, rst_cnt_d;
    logic in_reset;
    logic cpu_halted;
    assign in_reset = (rst_st_q != SSCR_RST_IDLE);
    // sleep, timebase and stop all stop instruction execution
    assign cpu_halted = (POWER_MODE_I == SSCR_MODE_SLEEP) ||
                        (POWER_MODE_I == SSCR_MODE_TIMEBASE) ||
                        (POWER_MODE_I == SSCR_MODE_STOP);
    assign stall_ovf = (stall_q == {STALL_WIDTH{1'b1}});

    // counts from reset release with no enable register at all
    always_comb begin
        stall_d = stall_q + 1'b1;
        if (clear_wr || in_reset || !osc_sync_q || cpu_halted) begin
            stall_d = '0;
        end else if (POWER_MODE_I == SSCR_MODE_SUB) begin
            stall_d = stall_q;
        end else if (stall_ovf) begin
            stall_d = '0;
        end
    end

    logic stall_fire;
    assign stall_fire = stall_ovf && !in_reset && osc_sync_q &&
                        !cpu_halted && !clear_wr &&
                        (POWER_MODE_I != SSCR_MODE_SUB);

    // ========================================================
    // internal reset pulse; low supply holds until it recovers
    always_comb begin
        rst_st_d = rst_st_q;
        rst_cnt_d = rst_cnt_q;
        unique case (rst_st_q)
            SSCR_RST_IDLE: begin
                if (low_rise) begin
                    rst_st_d = SSCR_RST_LOW;
                end else if (stall_fire) begin
                    rst_st_d = SSCR_RST_STALL;
                    rst_cnt_d = 8'h00;
                end
            end
            SSCR_RST_STALL: begin
                if (low_rise) begin
                    rst_st_d = SSCR_RST_LOW;
                end else if (MACHINE_TICK_I) begin
                    if (rst_cnt_q == 8'(RESET_CYCLES - 1)) begin
                        rst_st_d = SSCR_RST_IDLE;
                    end else begin
                        rst_cnt_d = rst_cnt_q + 8'h01;
                    end
                end
            end
            SSCR_RST_LOW: begin
                if (!low_conf) begin
                    rst_st_d = SSCR_RST_IDLE;
                end
            end
            // the fourth code of the two-bit state is never entered
            default: begin
                rst_st_d = SSCR_RST_IDLE;
            end
        endcase
    end

    // ========================================================
    // cause flags; set wins over a clearing write
    logic [7:0] ctrl_q, ctrl_d;
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr && !PWDATA_I[SSCR_LOW_FLAG_BIT]) begin
            ctrl_d[SSCR_LOW_FLAG_BIT] = 1'b0;
        end
        if (ctrl_wr && !PWDATA_I[SSCR_STALL_FLAG_BIT]) begin
            ctrl_d[SSCR_STALL_FLAG_BIT] = 1'b0;
        end
        if (low_rise) begin
            ctrl_d[SSCR_LOW_FLAG_BIT] = 1'b1;
        end
        if (stall_fire) begin
            ctrl_d[SSCR_STALL_FLAG_BIT] = 1'b1;
        end
    end

    // ========================================================
    // apb read data and outputs
    logic [31:0] rdata_d;
    logic ready_d, slverr_d;
    logic int_rst_d, wake_d;
    always_comb begin
        rdata_d = 32'h0000_0000;
        ready_d = 1'b0;
        slverr_d = 1'b0;
        // one wait state: answer in the second access cycle
        if (PSEL_I && PENABLE_I && !PREADY_O) begin
            ready_d = 1'b1;
            slverr_d = !hit_ctrl(PADDR_I);
            if (!PWRITE_I && hit_ctrl(PADDR_I)) begin
                // bits 5,4 fixed one, others reserved read zero
                rdata_d = {24'h00_0000, ctrl_q | SSCR_FIXED_ONES};
            end
        end
        int_rst_d = (rst_st_d != SSCR_RST_IDLE);
        wake_d = (rst_st_d == SSCR_RST_LOW) &&
                 (POWER_MODE_I == SSCR_MODE_STOP);
    end

    // ========================================================
    // registers; the cause flags see only the external reset
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            stall_q <= '0;
            rst_st_q <= SSCR_RST_IDLE;
            rst_cnt_q <= 8'h00;
            ctrl_q <= 8'h00;
            low_conf_prev_q <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            INT_RESET_O <= 1'b0;
            STOP_WAKE_O <= 1'b0;
        end else begin
            stall_q <= stall_d;
            rst_st_q <= rst_st_d;
            rst_cnt_q <= rst_cnt_d;
            ctrl_q <= ctrl_d;
            low_conf_prev_q <= low_conf;
            PRDATA_O <= rdata_d;
            PREADY_O <= ready_d;
            PSLVERR_O <= slverr_d;
            INT_RESET_O <= int_rst_d;
            STOP_WAKE_O <= wake_d;
        end
    end
endmodule : sscr_supervisor

// ### include/sscr_pkg.sv
// package for the supply and stall reset supervisor
package sscr_pkg;
    // ========================================================
    // register map
    localparam logic [11:0] SSCR_CTRL_STATUS_OFS = 12'h000;
    localparam logic [7:0] SSCR_CTRL_STATUS_RST = 8'h30;
    localparam int SSCR_STALL_FLAG_BIT = 0;
    localparam int SSCR_LOW_FLAG_BIT = 2;
    localparam int SSCR_CLEAR_BIT = 3;
    localparam logic [7:0] SSCR_FIXED_ONES = 8'h30;
    // ========================================================
    // timing
    localparam int SSCR_STALL_WIDTH = 20;
    localparam int SSCR_RESET_CYCLES = 5;
    localparam int SSCR_FILTER_CYCLES = 4;
    // ========================================================
    // power modes reported by the clock controller
    typedef enum logic [2:0] {
        SSCR_MODE_RUN,
        SSCR_MODE_SLEEP,
        SSCR_MODE_TIMEBASE,
        SSCR_MODE_STOP,
        SSCR_MODE_SUB
    } sscr_mode_t;
    // internal reset pulse machine
    typedef enum logic [1:0] {
        SSCR_RST_IDLE,
        SSCR_RST_STALL,
        SSCR_RST_LOW
    } sscr_rst_state_t;
endpackage : sscr_pkg

// ### include/sscr_flt_if.sv
// interface between the supervisor and its supply noise filter
`timescale 1ns/1ps
interface sscr_flt_if;
    logic raw_sync;
    logic confirmed;
    modport filt (input raw_sync, output confirmed);
    modport user (output raw_sync, input confirmed);
endinterface : sscr_flt_if

// ### hw/sscr_noise_filter.sv
// noise filter for the synchronised low-supply comparator output
`timescale 1ns/1ps
module sscr_noise_filter #(
    parameter int STABLE_CYCLES = sscr_pkg::SSCR_FILTER_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    sscr_flt_if.filt flt
);
    import sscr_pkg::*;

    // the confirm counter is eight bits wide, so longer windows cannot fit
    if (STABLE_CYCLES < 1 || STABLE_CYCLES > 255) begin : g_bad_len
        $error("filter length out of range");
    end

    logic [7:0] cnt_q, cnt_d;
    logic conf_q, conf_d;

    // ========================================================
    // confirm a level only after it stays put for the whole window
    always_comb begin
        cnt_d = cnt_q;
        conf_d = conf_q;
        if (flt.raw_sync == conf_q) begin
            cnt_d = 8'h00;
        end else if (cnt_q == 8'(STABLE_CYCLES - 1)) begin
            cnt_d = 8'h00;
            conf_d = flt.raw_sync;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
            conf_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            conf_q <= conf_d;
        end
    end

    assign flt.confirmed = conf_q;
endmodule : sscr_noise_filter

// ### testbench/sscr_supervisor_asserts.sv
// checker for the supply and stall reset supervisor
`timescale 1ns/1ps
module sscr_sup_asserts #(
    parameter int STALL_WIDTH = 20
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic OSC_RUN_I,
    input wire logic MACHINE_TICK_I,
    input wire sscr_pkg::sscr_mode_t POWER_MODE_I,
    input wire logic LOW_SUPPLY_I,
    input wire logic INT_RESET_O,
    input wire logic STOP_WAKE_O
);
    import sscr_pkg::*;
    // slack of 8 covers the pin synchronisers and the flag stage
    localparam int LIMIT = (1 << STALL_WIDTH) - 8;
    int run_q, run_d, low_q, low_d, tk_q, tk_d;
    logic clr;
    // ========================================
    // helper counters
    // clearing write, honoured at every access-phase edge
    assign clr = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0]
        && PADDR_I == 12'h000 && !PWDATA_I[3];
    // run length since last clear, supply-quiet time, ticks in reset
    always_comb begin
        run_d = run_q + 1;
        if (POWER_MODE_I == SSCR_MODE_SUB) run_d = run_q;
        else if (POWER_MODE_I != SSCR_MODE_RUN || !OSC_RUN_I || clr
            || INT_RESET_O) run_d = 0;
        low_d = LOW_SUPPLY_I ? 0 : low_q + int'(low_q < 15);
        tk_d = INT_RESET_O ? tk_q + int'(MACHINE_TICK_I) : 0;
    end
    // registers of the helper counters
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            run_q <= 0;
            low_q <= 15;
            tk_q <= 0;
        end else begin
            run_q <= run_d;
            low_q <= low_d;
            tk_q <= tk_d;
        end
    end
    // ========================================
    // properties
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    a_ready_one: assert property (PSEL_I && PENABLE_I && !PREADY_O
        |=> PREADY_O) else $error("no ready after access phase");
    a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_err_map: assert property (PREADY_O |-> PSLVERR_O == (PADDR_I != 0))
        else $error("error flag does not match address");
    a_read_fixed: assert property (
        PREADY_O && !PWRITE_I && !PSLVERR_O
        |-> (PRDATA_O & 32'hffff_fffa) == 32'h0000_0030)
        else $error("fixed read bits wrong");
    a_low_reset: assert property (LOW_SUPPLY_I [*8] |-> ##[0:4] INT_RESET_O)
        else $error("low supply gave no reset");
    a_glitch_kept: assert property (
        (POWER_MODE_I == SSCR_MODE_STOP && !LOW_SUPPLY_I) [*4]
        ##1 LOW_SUPPLY_I ##1 !LOW_SUPPLY_I |=> !$rose(INT_RESET_O) [*8])
        else $error("supply glitch caused reset");
    a_stop_wake: assert property (
        (POWER_MODE_I == SSCR_MODE_STOP && LOW_SUPPLY_I) [*8]
        |-> ##[0:4] STOP_WAKE_O) else $error("stop not ended");
    a_stall_quiet: assert property (
        $rose(INT_RESET_O) && low_q > 12 |-> run_q >= LIMIT)
        else $error("stall reset too early");
    a_stall_width: assert property (
        $fell(INT_RESET_O) && low_q > 12 |-> tk_q == 5)
        else $error("stall reset not five machine cycles");
endmodule : sscr_sup_asserts

bind sscr_supervisor sscr_sup_asserts #(.STALL_WIDTH(STALL_WIDTH)) u_chk (
    .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .OSC_RUN_I(OSC_RUN_I),
    .MACHINE_TICK_I(MACHINE_TICK_I), .POWER_MODE_I(POWER_MODE_I),
    .LOW_SUPPLY_I(LOW_SUPPLY_I), .INT_RESET_O(INT_RESET_O),
    .STOP_WAKE_O(STOP_WAKE_O));

// ### testbench/tb_top.sv
// self-checking bench for the supply and stall reset supervisor
`timescale 1ns/1ps
module tb_top;
    import sscr_pkg::*;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [7:0] d;
        logic [3:0] s;
        logic [7:0] r;
        logic e;
    } sscr_row_t;
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic osc = 1'h1, tick = 1'h0, low = 1'h0, rdy, err, irst, wake;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [3:0] pstrb = 4'h1;
    logic e;
    sscr_mode_t mode = SSCR_MODE_RUN;
    sscr_mode_t held [3] = '{SSCR_MODE_SLEEP, SSCR_MODE_TIMEBASE,
        SSCR_MODE_STOP};
    int n_mismatch = 0, checks = 0, cyc = 0, n_rst = 0, n_tk = 0, k;
    sscr_row_t rows [5] = '{'{1'h0, 12'h000, 8'h00, 4'h1, 8'h30, 1'h0},
        '{1'h0, 12'h004, 8'h00, 4'h1, 8'h00, 1'h1},
        '{1'h1, 12'h004, 8'h30, 4'h1, 8'h00, 1'h1},
        '{1'h1, 12'h000, 8'h35, 4'h0, 8'h00, 1'h0},
        '{1'h0, 12'h000, 8'h00, 4'h1, 8'h30, 1'h0}};
    // an 8-bit count keeps each expiry near 256 cycles
    sscr_supervisor #(.STALL_WIDTH(8)) u_dut (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
        .PRDATA_O(prdata), .PREADY_O(rdy), .PSLVERR_O(err),
        .OSC_RUN_I(osc), .MACHINE_TICK_I(tick), .POWER_MODE_I(mode),
        .LOW_SUPPLY_I(low), .INT_RESET_O(irst), .STOP_WAKE_O(wake));
    // ========================================
    // clock, machine tick, reset counters and hang guard
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        tick <= (cyc % 4 == 3);
        if (irst === 1'h1) n_rst <= n_rst + 1;
        if (irst === 1'h1 && tick) n_tk <= n_tk + 1;
        if (cyc == 10000) begin
            n_mismatch++;
            results();
        end
    end
    // ========================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // request held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [7:0] d, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (rdy !== 1'h1);
        r = prdata;
        e = err;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb
    task automatic rd(input logic [7:0] exp);
        apb(1'h0, 12'h000, 8'h00, 4'h1);
        chk(r, {24'h0, exp});
    endtask : rd
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask : cycles
    // bounded wait for the internal reset; settle then waits for its end with no bound
    task automatic wait_rst(input int lim);
        for (k = 0; k < lim && irst !== 1'h1; k++) @(posedge clk);
        chk(k < lim, 1);
    endtask : wait_rst
    task automatic settle();
        while (irst === 1'h1) @(posedge clk);
    endtask : settle
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    // ========================================
    // main sequence
    initial begin
        cycles(8);
        rst_n <= 1'h1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
            chk(e, rows[i].e);
            if (!rows[i].w) chk(r, {24'h0, rows[i].r});
        end
        $display("register rows done");
        k = n_rst;
        repeat (6) begin
            apb(1'h1, 12'h000, 8'h35, 4'h1);
            cycles(100);
        end
        chk(n_rst - k, 0);
        wait_rst(400);
        k = n_tk;
        settle();
        chk(n_tk - k, 5);
        rd(8'h31);
        apb(1'h1, 12'h000, 8'h39, 4'h1);
        rd(8'h31);
        apb(1'h1, 12'h000, 8'h38, 4'h1);
        rd(8'h30);
        $display("stall expiry done");
        k = n_rst;
        foreach (held[i]) begin
            mode <= held[i];
            cycles(400);
        end
        chk(n_rst - k, 0);
        low <= 1'h1;
        cycles(1);
        low <= 1'h0;
        cycles(20);
        chk(n_rst - k, 0);
        low <= 1'h1;
        wait_rst(20);
        cycles(12);
        chk(wake, 1);
        mode <= SSCR_MODE_RUN;
        low <= 1'h0;
        settle();
        rd(8'h34);
        apb(1'h1, 12'h000, 8'h3c, 4'h1);
        rd(8'h34);
        apb(1'h1, 12'h000, 8'h38, 4'h1);
        rd(8'h30);
        $display("low supply done");
        cycles(150);
        k = n_rst;
        osc <= 1'h0;
        cycles(400);
        osc <= 1'h1;
        cycles(100);
        apb(1'h1, 12'h000, 8'h30, 4'h1);
        cycles(200);
        mode <= SSCR_MODE_SUB;
        cycles(400);
        chk(n_rst - k, 0);
        mode <= SSCR_MODE_RUN;
        wait_rst(100);
        settle();
        rd(8'h31);
        rst_n <= 1'h0;
        cycles(2);
        rst_n <= 1'h1;
        rd(8'h30);
        $display("clock stop, sub mode and reset done");
        results();
    end
endmodule : tb_top
